// [design/pbcvd_pkg.sv]
// Constants for the port pin control block with converter pin overrides.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package pbcvd_pkg;
  localparam int PINS = 8;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_PORT = 8'h00;
  localparam logic [7:0] OFF_MODIFY = 8'h04;
  localparam logic [7:0] OFF_LATCH = 8'h08;
  localparam logic [7:0] OFF_DIR = 8'h0C;
  localparam logic [7:0] OFF_ANALOG = 8'h10;
  localparam logic [7:0] OFF_C1_HI = 8'h14;
  localparam logic [7:0] OFF_C2_LO = 8'h18;
  localparam logic [7:0] OFF_C2_HI = 8'h1C;
  localparam logic [7:0] OFF_GUARD = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // Values after reset
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_ANALOG = 8'hFF;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_CHAN = 8'h00;
  localparam logic [7:0] RST_GUARD = 8'h00;
  // Guard control fields
  localparam int GRD_B_OE = 7;
  localparam int GRD_A_OE = 6;
  localparam int GRD_POL = 5;
  localparam int TX_POL = 0;
  localparam logic [7:0] GRD_IMPL = 8'hE1;
  // Bits with no pin on the reduced variant
  localparam logic [7:0] C1_HI_NOPIN = 8'hFC;
  localparam logic [7:0] C2_HI_NOPIN = 8'hF8;
  // Analog channel number behind each bit
  localparam logic [5:0] C1_HI_CH [8] = '{6'h12, 6'h13, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23};
  localparam logic [5:0] C2_LO_CH [8] = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B};
  localparam logic [5:0] C2_HI_CH [8] = '{6'h1C, 6'h1D, 6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D};
  localparam logic [5:0] PRE_OFF = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/pbcvd_port.sv]
// Port pin control: direction, latch, analog read masking, output priority,
// converter secondary channel overrides and guard ring / TX outputs.
// Assumes pins sampled synchronously to clk_sys; converter sequencer outside.
// Function
// - Each port pin has its own direction bit, latch bit and input path.
// - Direction bit 1 turns the pin driver off; pin is an input.
// - Direction bit 0 drives the pin from its output latch.
// - Port data read returns pin levels; write goes to the latch.
// - Modify register writes are read-modify-write: pins sampled, masked bits replaced, stored in latch.
// - Analog-selected pins read as zero digitally.
// - Analog select never affects digital output driving.
// - Analog select bits reset to analog; software clears them.
// - Several enabled sources: the highest priority one owns the pin.
// - Fixed per-pin priority order from event input down to latch.
// - Secondary channel bit set connects that channel beside the primary.
// - A channel both primary and secondary counts only as primary.
// - Converter 2 low secondary channel bit forces the matching pin driver off.
// - Secondary connections and overrides act only with converter enabled.
// - Reduced variant: channel bits without pins read zero.
// - Bit 5 sets guard start level in precharge; bits 4-1 read zero.
// - Guard B holds level; in dual sample toggles at precharge start.
// - Dual sample with inverted polarity inverts second conversion outputs.
`timescale 1ns/1ps
module pbcvd_port #(
  parameter int REDUCED_VARIANT = 0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [pbcvd_pkg::AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [pbcvd_pkg::AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Package pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  // Peripheral output sources
  input wire logic edge_event_oe,
  input wire logic edge_event_out,
  input wire logic [3:0] pulse_oe,
  input wire logic [3:0] pulse_out,
  input wire logic programming_clock_oe,
  input wire logic programming_clock,
  input wire logic programming_data_oe,
  input wire logic programming_data,
  // Converter status from the sequencer
  input wire logic conv1_enable,
  input wire logic conv2_enable,
  input wire logic [5:0] conv1_primary_channel,
  input wire logic [5:0] conv2_primary_channel,
  input wire logic [5:0] precharge_time,
  input wire logic conversion_start_done,
  input wire logic precharge_start,
  input wire logic acquisition_start,
  input wire logic dual_sample_enable,
  input wire logic inverted_polarity_enable,
  input wire logic second_conversion,
  // Converter side results
  output logic [7:0] conv1_sec_connect,
  output logic [15:0] conv2_sec_connect,
  output logic tx_out,
  output logic tx_active
);

  if (REDUCED_VARIANT < 0 || REDUCED_VARIANT > 1) begin : g_chk
    $error("REDUCED_VARIANT must be 0 or 1");
  end

  localparam logic [7:0] C1_MASK = (REDUCED_VARIANT == 1) ? ~pbcvd_pkg::C1_HI_NOPIN : 8'hFF;
  localparam logic [7:0] C2_MASK = (REDUCED_VARIANT == 1) ? ~pbcvd_pkg::C2_HI_NOPIN : 8'hFF;

  logic [7:0] out_latch_reg;
  logic [7:0] pin_dir_reg;
  logic [7:0] analog_reg;
  logic [7:0] c1_hi_reg;
  logic [7:0] c2_lo_reg;
  logic [7:0] c2_hi_reg;
  logic [7:0] guard_reg;
  logic [7:0] wa_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic do_wr;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [7:0] pin_rd;
  logic [7:0] sec_ovr;
  logic [7:0] mux_val;
  logic guard_a_reg;
  logic guard_b_reg;
  logic tx_reg;
  logic go_prev_reg;
  logic go_rise;
  logic start_inv;
  logic pre_on;
  logic guard_a_act;
  logic guard_b_act;

  assign pin_rd = pin_in & ~analog_reg;
  assign do_wr = !s_awready && !s_wready && !s_bvalid;
  assign go_rise = conversion_start_done && !go_prev_reg;
  assign pre_on = precharge_time != pbcvd_pkg::PRE_OFF;
  assign start_inv = dual_sample_enable && inverted_polarity_enable && second_conversion;
  assign guard_a_act = conv1_enable && guard_reg[pbcvd_pkg::GRD_A_OE];
  assign guard_b_act = conv1_enable && guard_reg[pbcvd_pkg::GRD_B_OE];

  // Write channel: address and data taken in either order
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= pbcvd_pkg::RESP_OKAY;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        wa_reg <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wd_reg <= s_wdata;
        ws_reg <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? pbcvd_pkg::RESP_OKAY : pbcvd_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    case ({wa_reg[7:2], 2'b00})
      pbcvd_pkg::OFF_PORT, pbcvd_pkg::OFF_MODIFY, pbcvd_pkg::OFF_LATCH, pbcvd_pkg::OFF_DIR,
      pbcvd_pkg::OFF_ANALOG, pbcvd_pkg::OFF_C1_HI, pbcvd_pkg::OFF_C2_LO, pbcvd_pkg::OFF_C2_HI,
      pbcvd_pkg::OFF_GUARD, pbcvd_pkg::OFF_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Output latch; the modify register merges masked bits into sampled pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_latch_reg <= pbcvd_pkg::RST_LATCH;
    end else if (do_wr && ws_reg[0]) begin
      if (wa_reg == pbcvd_pkg::OFF_PORT || wa_reg == pbcvd_pkg::OFF_LATCH) begin
        out_latch_reg <= wd_reg[7:0];
      end else if (wa_reg == pbcvd_pkg::OFF_MODIFY && ws_reg[1]) begin
        out_latch_reg <= (pin_rd & ~wd_reg[15:8]) | (wd_reg[7:0] & wd_reg[15:8]);
      end
    end
  end

  // Direction and analog select; both start as inputs in analog mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_dir_reg <= pbcvd_pkg::RST_DIR;
      analog_reg <= pbcvd_pkg::RST_ANALOG;
    end else if (do_wr && ws_reg[0]) begin
      if (wa_reg == pbcvd_pkg::OFF_DIR) begin
        pin_dir_reg <= wd_reg[7:0];
      end
      if (wa_reg == pbcvd_pkg::OFF_ANALOG) begin
        analog_reg <= wd_reg[7:0];
      end
    end
  end

  // Secondary channel and guard control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c1_hi_reg <= pbcvd_pkg::RST_CHAN;
      c2_lo_reg <= pbcvd_pkg::RST_CHAN;
      c2_hi_reg <= pbcvd_pkg::RST_CHAN;
      guard_reg <= pbcvd_pkg::RST_GUARD;
    end else if (do_wr && ws_reg[0]) begin
      case (wa_reg)
        pbcvd_pkg::OFF_C1_HI: c1_hi_reg <= wd_reg[7:0] & C1_MASK;
        pbcvd_pkg::OFF_C2_LO: c2_lo_reg <= wd_reg[7:0];
        pbcvd_pkg::OFF_C2_HI: c2_hi_reg <= wd_reg[7:0] & C2_MASK;
        pbcvd_pkg::OFF_GUARD: guard_reg <= wd_reg[7:0] & pbcvd_pkg::GRD_IMPL;
        default: guard_reg <= guard_reg;
      endcase
    end
  end

  // Read channel; data captured when the address is taken
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case ({s_araddr[7:2], 2'b00})
      pbcvd_pkg::OFF_PORT: rd_val[7:0] = pin_rd;
      pbcvd_pkg::OFF_MODIFY: rd_val = 32'h0000_0000;
      pbcvd_pkg::OFF_LATCH: rd_val[7:0] = out_latch_reg;
      pbcvd_pkg::OFF_DIR: rd_val[7:0] = pin_dir_reg;
      pbcvd_pkg::OFF_ANALOG: rd_val[7:0] = analog_reg;
      pbcvd_pkg::OFF_C1_HI: rd_val[7:0] = c1_hi_reg;
      pbcvd_pkg::OFF_C2_LO: rd_val[7:0] = c2_lo_reg;
      pbcvd_pkg::OFF_C2_HI: rd_val[7:0] = c2_hi_reg;
      pbcvd_pkg::OFF_GUARD: rd_val[7:0] = guard_reg;
      pbcvd_pkg::OFF_STATUS: rd_val[10:0] = {guard_b_reg, guard_a_reg, tx_reg, ~pin_oe_n};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= pbcvd_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_val;
      s_rresp <= rd_ok ? pbcvd_pkg::RESP_OKAY : pbcvd_pkg::RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Secondary connections, dropping any channel that is also the primary
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv1_sec_connect <= 8'h00;
      conv2_sec_connect <= 16'h0000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        conv1_sec_connect[i] <= conv1_enable && c1_hi_reg[i]
          && conv1_primary_channel != pbcvd_pkg::C1_HI_CH[i];
        conv2_sec_connect[i] <= conv2_enable && c2_lo_reg[i]
          && conv2_primary_channel != pbcvd_pkg::C2_LO_CH[i];
        conv2_sec_connect[i+8] <= conv2_enable && c2_hi_reg[i]
          && conv2_primary_channel != pbcvd_pkg::C2_HI_CH[i];
      end
    end
  end

  // Pins carry converter 2 low channels; a primary pin is tri-stated elsewhere
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sec_ovr[i] = conv2_enable && c2_lo_reg[i] && conv2_primary_channel != pbcvd_pkg::C2_LO_CH[i];
    end
  end

  // Guard ring and TX sequencing on converter 1
  always_ff @(posedge clk_sys) begin
    if (rst || !conv1_enable) begin
      guard_a_reg <= 1'b0;
      guard_b_reg <= 1'b0;
      tx_reg <= 1'b0;
      go_prev_reg <= 1'b0;
    end else begin
      go_prev_reg <= conversion_start_done;
      if (precharge_start && pre_on) begin
        guard_a_reg <= guard_reg[pbcvd_pkg::GRD_POL] ^ start_inv;
        tx_reg <= guard_reg[pbcvd_pkg::TX_POL] ^ start_inv;
        if (dual_sample_enable) begin
          guard_b_reg <= ~guard_b_reg;
        end else begin
          guard_b_reg <= guard_reg[pbcvd_pkg::GRD_POL] ^ start_inv;
        end
      end else if (pre_on && acquisition_start) begin
        guard_a_reg <= ~guard_a_reg;
        tx_reg <= ~tx_reg;
      end else if (!pre_on && go_rise) begin
        // No precharge stage: start level and its toggle land together
        guard_a_reg <= ~(guard_reg[pbcvd_pkg::GRD_POL] ^ start_inv);
        tx_reg <= ~(guard_reg[pbcvd_pkg::TX_POL] ^ start_inv);
        guard_b_reg <= guard_reg[pbcvd_pkg::GRD_POL] ^ start_inv;
      end
    end
  end

  // Output priority; analog select plays no part in driving
  always_comb begin
    mux_val = out_latch_reg;
    if (edge_event_oe) begin
      mux_val[0] = edge_event_out;
    end else if (pulse_oe[0]) begin
      mux_val[0] = pulse_out[0];
    end
    for (int i = 1; i < 4; i++) begin
      if (pulse_oe[i]) begin
        mux_val[i] = pulse_out[i];
      end
    end
    if (guard_a_act) begin
      mux_val[5:4] = {2{guard_a_reg}};
    end
    if (programming_clock_oe) begin
      mux_val[6] = programming_clock;
    end else if (guard_b_act) begin
      mux_val[6] = guard_b_reg;
    end
    if (programming_data_oe) begin
      mux_val[7] = programming_data;
    end else if (guard_b_act) begin
      mux_val[7] = guard_b_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out <= 8'h00;
      pin_oe_n <= 8'hFF;
      tx_out <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      pin_out <= mux_val;
      pin_oe_n <= pin_dir_reg | sec_ovr;
      tx_out <= tx_reg;
      tx_active <= conv1_enable;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_input_mode: assert property (##1 (~pin_oe_n & $past(pin_dir_reg)) == 8'h00)
    else $error("input pin driven");
  a_latch_drive: assert property (pin_dir_reg == 8'h00 && sec_ovr == 8'h00 && !edge_event_oe
    && pulse_oe == 4'h0 && !guard_a_act |=> pin_oe_n == 8'h00 && pin_out[5:0] == $past(out_latch_reg[5:0]))
    else $error("latch not driven");
  a_rmw_merge: assert property (do_wr && wa_reg == pbcvd_pkg::OFF_MODIFY && ws_reg[1:0] == 2'b11
    |=> out_latch_reg == $past((pin_rd & ~wd_reg[15:8]) | (wd_reg[7:0] & wd_reg[15:8])))
    else $error("modify merge wrong");
  a_analog_read: assert property (s_arvalid && s_arready && s_araddr == pbcvd_pkg::OFF_PORT
    |=> s_rvalid && (s_rdata[7:0] & $past(analog_reg)) == 8'h00 && s_rdata[7:0] == $past(pin_in & ~analog_reg))
    else $error("analog pin read nonzero");
  a_analog_reset: assert property ($fell(rst) |-> analog_reg == 8'hFF && pin_dir_reg == 8'hFF)
    else $error("reset state wrong");
  a_pin0_prio: assert property (edge_event_oe && pulse_oe[0] |=> pin_out[0] == $past(edge_event_out))
    else $error("pin 0 priority wrong");
  a_sec_tristate: assert property (sec_ovr != 8'h00 |=> (pin_oe_n & $past(sec_ovr)) == $past(sec_ovr))
    else $error("secondary pin driven");
  a_sec_enable: assert property (!conv2_enable |=> conv2_sec_connect == 16'h0000)
    else $error("secondary without enable");
  a_primary_wins: assert property (conv2_primary_channel == 6'h14 |=> !conv2_sec_connect[0])
    else $error("primary also secondary");
  a_reduced_zero: assert property ((c1_hi_reg & ~C1_MASK) == 8'h00 && (c2_hi_reg & ~C2_MASK) == 8'h00)
    else $error("missing channel bit set");
  a_guard_release: assert property (!conv1_enable && !programming_clock_oe
    |=> pin_out[6:4] == $past(out_latch_reg[6:4]) && !tx_active)
    else $error("guard held pins while off");
  a_guard_b_hold: assert property (conv1_enable && !precharge_start && !go_rise |=> $stable(guard_b_reg))
    else $error("guard B moved");

  c_rmw_write: cover property (do_wr && wa_reg == pbcvd_pkg::OFF_MODIFY);
  c_guard_toggle: cover property (pre_on && acquisition_start && guard_a_act);
  c_sec_override: cover property (sec_ovr != 8'h00 && pin_dir_reg != 8'hFF);
  c_inverted_second: cover property (precharge_start && start_inv);

endmodule

// [verification/pbcvd_pin_model.sv]
// Pin model: sensing electrodes and outside drivers at the eight pins.
// Assumes the bench sets the level that the outside world puts on each pin.
`timescale 1ns/1ps
module pbcvd_pin_model (
  // Port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // Outside world
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // A pin whose driver is off shows the outside level, never a stale port value
  assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule

// [verification/test_port_b_cvd_pin_control.sv]
// Self-checking bench for the port pin control block.
// Assumes the pin model at the pins and an AXI4-Lite master of its own.
`timescale 1ns/1ps
module test_port_b_cvd_pin_control;
  logic clk_sys, rst;
  logic [7:0] s_awaddr, s_araddr, pin_in, pin_out, pin_oe_n, ext_level, conv1_sec_connect, lat, pins, m;
  logic [31:0] s_wdata, s_rdata, rnd, rd;
  logic [3:0] s_wstrb, pulse_oe, pulse_out;
  logic [1:0] s_bresp, s_rresp, last_bresp, last_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic edge_event_oe, edge_event_out, programming_clock_oe, programming_clock, programming_data_oe;
  logic programming_data, conv1_enable, conv2_enable, conversion_start_done, precharge_start;
  logic acquisition_start, dual_sample_enable, inverted_polarity_enable, second_conversion, tx_out, tx_active;
  logic [5:0] conv1_primary_channel, conv2_primary_channel, precharge_time;
  logic [15:0] conv2_sec_connect, r;
  int n_errors, tests_run;

  pbcvd_port pbcvd_port_i (
    .clk_sys(clk_sys), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .edge_event_oe(edge_event_oe),
    .edge_event_out(edge_event_out), .pulse_oe(pulse_oe), .pulse_out(pulse_out),
    .programming_clock_oe(programming_clock_oe), .programming_clock(programming_clock),
    .programming_data_oe(programming_data_oe), .programming_data(programming_data),
    .conv1_enable(conv1_enable), .conv2_enable(conv2_enable), .conv1_primary_channel(conv1_primary_channel),
    .conv2_primary_channel(conv2_primary_channel), .precharge_time(precharge_time),
    .conversion_start_done(conversion_start_done), .precharge_start(precharge_start),
    .acquisition_start(acquisition_start), .dual_sample_enable(dual_sample_enable),
    .inverted_polarity_enable(inverted_polarity_enable), .second_conversion(second_conversion),
    .conv1_sec_connect(conv1_sec_connect), .conv2_sec_connect(conv2_sec_connect), .tx_out(tx_out),
    .tx_active(tx_active)
  );
  pbcvd_pin_model pbcvd_pin_model_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h00000000);
  endfunction

  // Expected pin values from the fixed per-pin source order
  function automatic logic [7:0] prio(input logic [7:0] l, input logic [15:0] q);
    logic [7:0] p;
    p = l;
    for (int i = 0; i < 4; i++) begin
      if (q[2 + i]) p[i] = q[6 + i];
    end
    if (q[0]) p[0] = q[1];
    if (q[13]) p[6] = q[12];
    if (q[11]) p[7] = q[10];
    return p;
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // A bus answer that never comes ends the run
  task automatic hung(input int n);
    if (n >= 64) begin
      n_errors++;
      $display("Error bus answer expected within 64 cycles seen none");
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] mk = 8'h00);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= {16'h0000, mk, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1 && n < 64);
    last_bresp = s_bresp;
    s_bready <= 1'b0;
    tick(1);
    hung(n);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && n < 64);
    d = s_rdata;
    last_rresp = s_rresp;
    s_rready <= 1'b0;
    tick(1);
    hung(n);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a, rd);
    chk(what, exp, rd[7:0]);
  endtask

  task automatic periph(input logic [15:0] q);
    edge_event_oe <= q[0];
    edge_event_out <= q[1];
    pulse_oe <= q[5:2];
    pulse_out <= q[9:6];
    {programming_clock_oe, programming_clock, programming_data_oe, programming_data} <= q[13:10];
  endtask

  // Stage pulse 0 precharge, 1 acquisition, 2 start bit rise
  task automatic stage(input int k);
    precharge_start <= (k == 0);
    acquisition_start <= (k == 1);
    conversion_start_done <= (k == 2);
    tick(1);
    {precharge_start, acquisition_start, conversion_start_done} <= 3'b000;
    tick(3);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 53'h0;
    {conv1_enable, conv2_enable, dual_sample_enable, inverted_polarity_enable, second_conversion} = 5'h00;
    {conversion_start_done, precharge_start, acquisition_start} = 3'h0;
    {conv1_primary_channel, conv2_primary_channel, precharge_time} = 18'h0;
    s_wstrb = 4'hF;
    ext_level = 8'h00;
    n_errors = 0;
    tests_run = 0;
    rnd = 32'h708BE12E;
    periph(16'h0000);
    tick(5);
    rst <= 1'b0;
    tick(1);
    chk("reset drivers", pbcvd_pkg::RST_DIR, pin_oe_n);
    for (int i = 0; i < 7; i++) begin
      m = (i == 1) ? pbcvd_pkg::RST_DIR : (i == 2) ? pbcvd_pkg::RST_ANALOG : pbcvd_pkg::RST_CHAN;
      rchk("reset value", pbcvd_pkg::OFF_LATCH + 8'(4 * i), m);
    end
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      m = (i == 6) ? pbcvd_pkg::GRD_IMPL : 8'hFF;
      wr(pbcvd_pkg::OFF_LATCH + 8'(4 * i), rnd[7:0]);
      rchk("read back", pbcvd_pkg::OFF_LATCH + 8'(4 * i), rnd[7:0] & m);
    end
    wr(8'h28, 8'h5A);
    chk("unmapped bresp", {6'h00, pbcvd_pkg::RESP_SLVERR}, {6'h00, last_bresp});
    rchk("unmapped rdata", 8'h28, 8'h00);
    chk("unmapped rresp", {6'h00, pbcvd_pkg::RESP_SLVERR}, {6'h00, last_rresp});
    $display("Test registers finished");

    // Pins 3-0 drive, 7-4 listen to the outside
    wr(pbcvd_pkg::OFF_ANALOG, 8'h00);
    wr(pbcvd_pkg::OFF_DIR, 8'hF0);
    rnd = lfsr(rnd);
    ext_level <= rnd[15:8];
    lat = rnd[7:0];
    pins = {rnd[15:12], lat[3:0]};
    wr(pbcvd_pkg::OFF_PORT, lat);
    rchk("latch", pbcvd_pkg::OFF_LATCH, lat);
    chk("drivers", 8'hF0, pin_oe_n);
    chk("pin drive", {4'h0, lat[3:0]}, {4'h0, pin_out[3:0]});
    rchk("port read", pbcvd_pkg::OFF_PORT, pins);
    rnd = lfsr(rnd);
    wr(pbcvd_pkg::OFF_ANALOG, rnd[7:0]);
    rchk("analog read", pbcvd_pkg::OFF_PORT, pins & ~rnd[7:0]);
    chk("analog drive", {4'h0, lat[3:0]}, {4'h0, pin_out[3:0]});
    wr(pbcvd_pkg::OFF_ANALOG, 8'h00);
    // Mask 0 first: the latch picks up the levels of the input pins
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      m = (k == 0) ? 8'h00 : rnd[15:8];
      lat = (pins & ~m) | (rnd[7:0] & m);
      wr(pbcvd_pkg::OFF_MODIFY, rnd[7:0], m);
      rchk("modify", pbcvd_pkg::OFF_LATCH, lat);
      pins = {pins[7:4], lat[3:0]};
    end
    $display("Test port finished");

    wr(pbcvd_pkg::OFF_DIR, 8'h00);
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      r = (k == 0) ? 16'h3FFD : rnd[15:0];
      periph(r);
      tick(2);
      chk("priority", prio(lat, r), pin_out);
    end
    periph(16'h0000);
    $display("Test priority finished");

    rnd = lfsr(rnd);
    wr(pbcvd_pkg::OFF_C2_LO, rnd[7:0] | 8'h08);
    tick(2);
    chk("tristate off", 8'h00, pin_oe_n);
    chk("connect off", 8'h00, conv2_sec_connect[7:0]);
    conv2_primary_channel <= pbcvd_pkg::C2_LO_CH[3];
    conv2_enable <= 1'b1;
    tick(3);
    chk("tristate", rnd[7:0] & 8'hF7, pin_oe_n);
    chk("connect lo", rnd[7:0] & 8'hF7, conv2_sec_connect[7:0]);
    wr(pbcvd_pkg::OFF_C2_HI, rnd[15:8]);
    tick(2);
    chk("connect hi", rnd[15:8], conv2_sec_connect[15:8]);
    conv1_enable <= 1'b1;
    wr(pbcvd_pkg::OFF_C1_HI, rnd[23:16]);
    tick(2);
    chk("connect c1", rnd[23:16], conv1_sec_connect);
    conv2_enable <= 1'b0;
    $display("Test channels finished");

    wr(pbcvd_pkg::OFF_LATCH, 8'h50);
    precharge_time <= 6'h05;
    wr(pbcvd_pkg::OFF_GUARD, 8'hE0);
    stage(0);
    chk("guard start", 8'h0F, {4'h0, pin_out[7:4]});
    chk("tx start", 8'h00, {7'h00, tx_out});
    chk("tx active", 8'h01, {7'h00, tx_active});
    stage(1);
    chk("guard acq", 8'h0C, {4'h0, pin_out[7:4]});
    chk("tx acq", 8'h01, {7'h00, tx_out});
    precharge_time <= pbcvd_pkg::PRE_OFF;
    stage(0);
    stage(2);
    chk("guard no pre", 8'h0C, {4'h0, pin_out[7:4]});
    // Plain precharge first, so that the inverted start levels differ from the ones held
    precharge_time <= 6'h05;
    stage(0);
    {dual_sample_enable, inverted_polarity_enable, second_conversion} <= 3'b111;
    stage(0);
    chk("guard inverted", 8'h00, {4'h0, pin_out[7:4]});
    chk("tx inverted", 8'h01, {7'h00, tx_out});
    rchk("guard kept", pbcvd_pkg::OFF_GUARD, 8'hE0);
    {dual_sample_enable, inverted_polarity_enable, second_conversion} <= 3'b000;
    wr(pbcvd_pkg::OFF_GUARD, 8'hA0);
    tick(2);
    chk("guard a off", 8'h01, {6'h00, pin_out[5:4]});
    conv1_enable <= 1'b0;
    tick(3);
    chk("guard released", 8'h05, {4'h0, pin_out[7:4]});
    chk("tx released", 8'h00, {7'h00, tx_active});
    $display("Test guard finished");
    give_verdict();
  end
endmodule
